/* File: amu_core.sv */
// Contract
// - byte/word add-one, subtract-one on register: 2 cycles, N Z V set, carry kept
// - long add-one, subtract-one on register: 4 cycles, same flags, carry kept
// - memory add-one/subtract-one: read-modify-write, 3 (long 5) plus addressing plus twice access correction
// - compare long immediate: 3 cycles, accumulator minus immediate, four flags, no result
// - implied word compare: high half minus low half, 2 cycles, flags only
// - implied unsigned byte divide: high word by low byte, quotient low, remainder high
// - unsigned word divide: 32-bit accumulator by word, quotient accumulator, remainder operand
// - implied unsigned byte divide: 3 zero, 6 overflow, 14 normal; only V, C change
// - unsigned byte divide by register: 13 normal, 5 overflow, 3 zero divisor
// - unsigned word divide by register: 21 normal, 5 overflow, 3 zero divisor
// - unsigned byte divide by memory: 17, 7, 5 plus addressing correction
// - memory divide: one access correction on error, two when completing normally
// - implied unsigned byte multiply: 3 when high byte zero, else 7
// - implied unsigned word multiply: 3 when high word zero, else 11
// - word products 32 bits, byte products 16 bits, multiplies touch no flag
// - implied signed byte divide: 3 zero, 18 normal, 8 or 18 on overflow
// - signed word divide by register: 30 positive dividend, 31 negative
// - implied signed byte multiply: 3 high byte zero, 12 positive, 13 negative
// - signed overflow: shorter count if caught before, longer if caught after
module amu_core #(
  parameter int CORR_W = 4  // width of each correction count
) (
  input wire logic clk_sys,  // core clock
  input wire logic arst_n,  // asynchronous reset, active low
  input wire logic [4:0] address,  // byte address
  input wire logic read,  // read request
  input wire logic write,  // write request
  input wire logic [31:0] writedata,  // write data
  input wire logic [3:0] byteenable,  // write byte lanes
  output logic [31:0] readdata,  // read data
  output logic waitrequest,  // bus stall
  output logic opBusy,  // operation running
  output logic opDone  // final cycle of an operation
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] acc_ff, opnd_ff, pendAcc_ff, pendOpnd_ff, rdData_ff;
  amu_pkg::amu_flags_t flags_ff, pendFlags_ff;
  logic [CORR_W-1:0] corrAddr_ff, corrAcc_ff;
  amu_pkg::amu_op_t op_ff;
  logic mem_ff, waitReq_ff, busy_ff, done_ff, doneSticky_ff;
  logic [7:0] cnt_ff, lastCyc_ff;
  amu_pkg::amu_state_t state_ff, nxt_state;
  logic [31:0] nxt_pendAcc, nxt_pendOpnd, rdMux;
  amu_pkg::amu_flags_t nxt_pendFlags;
  logic [7:0] nxt_cyc;
  logic ack, wrTake, start, cmdMem, stepSub, stepLong;
  logic [4:0] stepSh;
  amu_pkg::amu_op_t cmdOp;
  amu_pkg::amu_step_t stepRes;
  amu_pkg::amu_flags_t compare_long, compare_word;
  amu_pkg::amu_div_t udImp, udByte, udWord, sdByte, sdWord;
  logic [15:0] ubProd;
  logic signed [15:0] sbProd;
  logic [31:0] uwProd;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    end
    return m;
  endfunction : beMerge

  // operand aligned to bit 31 so one adder serves every width
  function automatic amu_pkg::amu_step_t stepOne(input logic [31:0] v, input logic [4:0] sh,
                                                 input logic sub, input logic cin);
    logic [31:0] t, r, one;
    amu_pkg::amu_step_t s;
    t = v << sh;
    one = 32'h0000_0001 << sh;
    r = sub ? t - one : t + one;
    s.res = (r >> sh) | (v & ~(32'hFFFF_FFFF >> sh));
    s.flg.n = r[31];
    s.flg.z = (r == 32'h0000_0000);
    s.flg.v = sub ? (t[31] & ~r[31]) : (~t[31] & r[31]);
    s.flg.c = cin;
    return s;
  endfunction : stepOne

  function automatic amu_pkg::amu_flags_t cmpSub(input logic [31:0] a, input logic [31:0] b,
                                                 input logic [4:0] sh);
    logic [31:0] ta, tb;
    logic [32:0] d;
    amu_pkg::amu_flags_t f;
    ta = a << sh;
    tb = b << sh;
    d = {1'b0, ta} - {1'b0, tb};
    f.n = d[31];
    f.z = (d[31:0] == 32'h0000_0000);
    f.v = (ta[31] ^ tb[31]) & (ta[31] ^ d[31]);
    f.c = d[32];
    return f;
  endfunction : cmpSub

  function automatic amu_pkg::amu_div_t udiv(input logic [31:0] dvd, input logic [15:0] dvs,
                                             input logic isByte);
    logic [31:0] q, r, lim, ds;
    amu_pkg::amu_div_t d;
    lim = isByte ? amu_pkg::LIM_BYTE : amu_pkg::LIM_WORD;
    d.zero = (dvs == 16'h0000);
    ds = d.zero ? 32'h0000_0001 : {16'h0000, dvs};
    q = dvd / ds;
    r = dvd % ds;
    d.pre = !d.zero && (q >= lim);
    d.post = 1'b0;
    d.neg = 1'b0;
    d.quo = q[15:0];
    d.rem = r[15:0];
    return d;
  endfunction : udiv

  // magnitude divide, then signs; pre means the quotient can't fit at all
  function automatic amu_pkg::amu_div_t sdiv(input logic [31:0] dvd, input logic [15:0] dvs,
                                             input logic isByte);
    logic [31:0] q, r, lim, dm, ds;
    logic [15:0] sm;
    logic qNeg;
    amu_pkg::amu_div_t d;
    lim = isByte ? amu_pkg::LIM_BYTE : amu_pkg::LIM_WORD;
    d.neg = dvd[31];
    qNeg = dvd[31] ^ dvs[15];
    dm = d.neg ? 32'h0000_0000 - dvd : dvd;
    sm = dvs[15] ? 16'h0000 - dvs : dvs;
    d.zero = (dvs == 16'h0000);
    ds = d.zero ? 32'h0000_0001 : {16'h0000, sm};
    q = dm / ds;
    r = dm % ds;
    d.pre = !d.zero && (q >= lim);
    d.post = !d.zero && !d.pre && (qNeg ? (q > (lim >> 1)) : (q >= (lim >> 1)));
    d.quo = qNeg ? 16'h0000 - q[15:0] : q[15:0];
    d.rem = d.neg ? 16'h0000 - r[15:0] : r[15:0];
    return d;
  endfunction : sdiv

  function automatic logic [7:0] memCyc(input logic [7:0] base, input logic twice);
    logic [7:0] c8;
    c8 = 8'(corrAcc_ff);
    return base + 8'(corrAddr_ff) + (twice ? (c8 << 1) : c8);
  endfunction : memCyc

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // writes wait while an operation runs so destinations cannot be disturbed
  assign ack = (read | write) & waitReq_ff & ~(write & (state_ff != amu_pkg::ST_IDLE));
  assign wrTake = write & ~waitReq_ff;
  assign start = wrTake & (address == amu_pkg::OFS_CMD) & byteenable[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= ~ack;
    end
  end

  always_comb begin
    rdMux = amu_pkg::RST_WORD;
    case (address)
      amu_pkg::OFS_CMD: begin
        rdMux[3:0] = op_ff;
        rdMux[amu_pkg::CMD_MEM_BIT] = mem_ff;
      end
      amu_pkg::OFS_ACC: rdMux = acc_ff;
      amu_pkg::OFS_OPND: rdMux = opnd_ff;
      amu_pkg::OFS_FLAGS: rdMux[3:0] = flags_ff;
      amu_pkg::OFS_CORR: begin
        rdMux[CORR_W-1:0] = corrAddr_ff;
        rdMux[amu_pkg::CORR_ACC_LSB +: CORR_W] = corrAcc_ff;
      end
      amu_pkg::OFS_STATUS: begin
        rdMux[amu_pkg::STAT_BUSY_BIT] = busy_ff;
        rdMux[amu_pkg::STAT_DONE_BIT] = doneSticky_ff;
        rdMux[amu_pkg::STAT_CYC_LSB +: 8] = lastCyc_ff;
      end
      default: rdMux = amu_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff <= amu_pkg::RST_WORD;
    end else if (ack & read) begin
      rdData_ff <= rdMux;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      corrAddr_ff <= '0;
      corrAcc_ff <= '0;
    end else if (wrTake && address == amu_pkg::OFS_CORR) begin
      if (byteenable[0]) corrAddr_ff <= writedata[CORR_W-1:0];
      if (byteenable[1]) corrAcc_ff <= writedata[amu_pkg::CORR_ACC_LSB +: CORR_W];
    end
  end

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  assign cmdOp = amu_pkg::amu_op_t'(writedata[3:0]);
  assign cmdMem = writedata[amu_pkg::CMD_MEM_BIT];
  assign stepSub = cmdOp inside {amu_pkg::OP_SUB_ONE_BYTE, amu_pkg::OP_SUB_ONE_WORD,
                                 amu_pkg::OP_SUB_ONE_LONG};
  assign stepLong = cmdOp inside {amu_pkg::OP_ADD_ONE_LONG, amu_pkg::OP_SUB_ONE_LONG};
  assign stepSh = stepLong ? amu_pkg::SH_LONG :
                  (cmdOp inside {amu_pkg::OP_ADD_ONE_WORD, amu_pkg::OP_SUB_ONE_WORD}) ?
                  amu_pkg::SH_WORD : amu_pkg::SH_BYTE;
  assign stepRes = stepOne(opnd_ff, stepSh, stepSub, flags_ff.c);
  assign compare_long = cmpSub(acc_ff, opnd_ff, amu_pkg::SH_LONG);
  assign compare_word = cmpSub({16'h0000, acc_ff[31:16]}, {16'h0000, acc_ff[15:0]}, amu_pkg::SH_WORD);
  assign udImp = udiv({16'h0000, acc_ff[31:16]}, {8'h00, acc_ff[7:0]}, 1'b1);
  assign udByte = udiv({16'h0000, acc_ff[15:0]}, {8'h00, opnd_ff[7:0]}, 1'b1);
  assign udWord = udiv(acc_ff, opnd_ff[15:0], 1'b0);
  assign sdByte = sdiv({{16{acc_ff[31]}}, acc_ff[31:16]}, {{8{acc_ff[7]}}, acc_ff[7:0]}, 1'b1);
  assign sdWord = sdiv(acc_ff, opnd_ff[15:0], 1'b0);
  assign ubProd = 16'(acc_ff[23:16]) * 16'(acc_ff[7:0]);
  assign uwProd = 32'(acc_ff[31:16]) * 32'(acc_ff[15:0]);
  assign sbProd = 16'($signed(acc_ff[23:16])) * 16'($signed(acc_ff[7:0]));

  // divides on error leave both destinations untouched
  always_comb begin
    nxt_pendAcc = acc_ff;
    nxt_pendOpnd = opnd_ff;
    nxt_pendFlags = flags_ff;
    nxt_cyc = amu_pkg::CYC_MIN;
    case (cmdOp)
      amu_pkg::OP_ADD_ONE_BYTE, amu_pkg::OP_SUB_ONE_BYTE, amu_pkg::OP_ADD_ONE_WORD,
      amu_pkg::OP_SUB_ONE_WORD, amu_pkg::OP_ADD_ONE_LONG, amu_pkg::OP_SUB_ONE_LONG: begin
        nxt_pendOpnd = stepRes.res;
        nxt_pendFlags = stepRes.flg;
        if (cmdMem) begin
          nxt_cyc = memCyc(stepLong ? amu_pkg::CYC_STEP_MEM_L : amu_pkg::CYC_STEP_MEM, 1'b1);
        end else begin
          nxt_cyc = stepLong ? amu_pkg::CYC_STEP_REG_L : amu_pkg::CYC_STEP_REG;
        end
      end
      amu_pkg::OP_COMPARE_LONG: begin
        nxt_pendFlags = compare_long;
        nxt_cyc = amu_pkg::CYC_CMP_LONG;
      end
      amu_pkg::OP_COMPARE_WORD: begin
        nxt_pendFlags = compare_word;
        nxt_cyc = amu_pkg::CYC_CMP_WORD;
      end
      amu_pkg::OP_UB_QUOT_IMP: begin
        nxt_pendFlags.v = udImp.zero | udImp.pre;
        nxt_pendFlags.c = udImp.zero;
        if (udImp.zero) nxt_cyc = amu_pkg::CYC_UBQ_IMP_ZERO;
        else if (udImp.pre) nxt_cyc = amu_pkg::CYC_UBQ_IMP_OVF;
        else begin
          nxt_cyc = amu_pkg::CYC_UBQ_IMP_NORM;
          nxt_pendAcc[7:0] = udImp.quo[7:0];
          nxt_pendAcc[23:16] = udImp.rem[7:0];
        end
      end
      amu_pkg::OP_UB_QUOT: begin
        nxt_pendFlags.v = udByte.zero | udByte.pre;
        nxt_pendFlags.c = udByte.zero;
        if (udByte.zero) nxt_cyc = cmdMem ? amu_pkg::CYC_UBQ_MEM_ZERO : amu_pkg::CYC_UBQ_REG_ZERO;
        else if (udByte.pre) nxt_cyc = cmdMem ? amu_pkg::CYC_UBQ_MEM_OVF : amu_pkg::CYC_UBQ_REG_OVF;
        else begin
          nxt_cyc = cmdMem ? amu_pkg::CYC_UBQ_MEM_NORM : amu_pkg::CYC_UBQ_REG_NORM;
          nxt_pendAcc[7:0] = udByte.quo[7:0];
          nxt_pendOpnd[7:0] = udByte.rem[7:0];
        end
        if (cmdMem) nxt_cyc = memCyc(nxt_cyc, !(udByte.zero | udByte.pre));
      end
      amu_pkg::OP_UW_QUOT: begin
        nxt_pendFlags.v = udWord.zero | udWord.pre;
        nxt_pendFlags.c = udWord.zero;
        if (udWord.zero) nxt_cyc = cmdMem ? amu_pkg::CYC_UWQ_MEM_ZERO : amu_pkg::CYC_UWQ_REG_ZERO;
        else if (udWord.pre) nxt_cyc = cmdMem ? amu_pkg::CYC_UWQ_MEM_OVF : amu_pkg::CYC_UWQ_REG_OVF;
        else begin
          nxt_cyc = cmdMem ? amu_pkg::CYC_UWQ_MEM_NORM : amu_pkg::CYC_UWQ_REG_NORM;
          nxt_pendAcc[15:0] = udWord.quo;
          nxt_pendOpnd[15:0] = udWord.rem;
        end
        if (cmdMem) nxt_cyc = memCyc(nxt_cyc, !(udWord.zero | udWord.pre));
      end
      amu_pkg::OP_UB_PROD_IMP: begin
        nxt_pendAcc[15:0] = ubProd;
        nxt_cyc = (acc_ff[23:16] == 8'h00) ? amu_pkg::CYC_PROD_ZERO : amu_pkg::CYC_UBP;
      end
      amu_pkg::OP_UW_PROD_IMP: begin
        nxt_pendAcc = uwProd;
        nxt_cyc = (acc_ff[31:16] == 16'h0000) ? amu_pkg::CYC_PROD_ZERO : amu_pkg::CYC_UWP;
      end
      amu_pkg::OP_SB_PROD_IMP: begin
        nxt_pendAcc[15:0] = sbProd;
        if (acc_ff[23:16] == 8'h00) nxt_cyc = amu_pkg::CYC_PROD_ZERO;
        else nxt_cyc = sbProd[15] ? amu_pkg::CYC_SBP_NEG : amu_pkg::CYC_SBP_POS;
      end
      amu_pkg::OP_SB_QUOT_IMP: begin
        nxt_pendFlags.v = sdByte.zero | sdByte.pre | sdByte.post;
        nxt_pendFlags.c = sdByte.zero;
        if (sdByte.zero) nxt_cyc = amu_pkg::CYC_SBQ_ZERO;
        else if (sdByte.pre) nxt_cyc = amu_pkg::CYC_SBQ_OVF_PRE;
        else if (sdByte.post) nxt_cyc = amu_pkg::CYC_SBQ_OVF_POST;
        else begin
          nxt_cyc = amu_pkg::CYC_SBQ_NORM;
          nxt_pendAcc[7:0] = sdByte.quo[7:0];
          nxt_pendAcc[23:16] = sdByte.rem[7:0];
        end
      end
      amu_pkg::OP_SW_QUOT: begin
        nxt_pendFlags.v = sdWord.zero | sdWord.pre | sdWord.post;
        nxt_pendFlags.c = sdWord.zero;
        if (sdWord.zero) nxt_cyc = amu_pkg::CYC_SWQ_ZERO;
        else if (sdWord.pre) nxt_cyc = amu_pkg::CYC_SWQ_OVF_PRE + 8'(sdWord.neg);
        else if (sdWord.post) nxt_cyc = amu_pkg::CYC_SWQ_OVF_POST + 8'(sdWord.neg);
        else begin
          nxt_cyc = amu_pkg::CYC_SWQ_NORM + 8'(sdWord.neg);
          nxt_pendAcc[15:0] = sdWord.quo;
          nxt_pendOpnd[15:0] = sdWord.rem;
        end
        if (cmdMem) begin
          nxt_cyc = memCyc(nxt_cyc + 8'(!sdWord.zero), !(sdWord.zero | sdWord.pre | sdWord.post));
        end
      end
      default: nxt_cyc = amu_pkg::CYC_MIN;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    case (state_ff)
      amu_pkg::ST_IDLE: nxt_state = start ? amu_pkg::ST_RUN : amu_pkg::ST_IDLE;
      amu_pkg::ST_RUN: nxt_state = (cnt_ff == 8'h00) ? amu_pkg::ST_LAST : amu_pkg::ST_RUN;
      amu_pkg::ST_LAST: nxt_state = amu_pkg::ST_IDLE;
      default: nxt_state = amu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= amu_pkg::ST_IDLE;
      cnt_ff <= amu_pkg::RST_CYC;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start) cnt_ff <= nxt_cyc - amu_pkg::CYC_MIN;
      else if (state_ff == amu_pkg::ST_RUN && cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
      busy_ff <= (nxt_state != amu_pkg::ST_IDLE);
      done_ff <= (nxt_state == amu_pkg::ST_LAST);
    end
  end

  // results are computed at the start but held aside until the last cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pendAcc_ff <= amu_pkg::RST_WORD;
      pendOpnd_ff <= amu_pkg::RST_WORD;
      pendFlags_ff <= amu_pkg::RST_FLAGS;
      op_ff <= amu_pkg::amu_op_t'(amu_pkg::RST_OP);
      mem_ff <= 1'b0;
      lastCyc_ff <= amu_pkg::RST_CYC;
    end else if (start) begin
      pendAcc_ff <= nxt_pendAcc;
      pendOpnd_ff <= nxt_pendOpnd;
      pendFlags_ff <= nxt_pendFlags;
      op_ff <= cmdOp;
      mem_ff <= cmdMem;
      lastCyc_ff <= nxt_cyc;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= amu_pkg::RST_WORD;
      opnd_ff <= amu_pkg::RST_WORD;
      flags_ff <= amu_pkg::RST_FLAGS;
    end else if (state_ff == amu_pkg::ST_LAST) begin
      acc_ff <= pendAcc_ff;
      opnd_ff <= pendOpnd_ff;
      flags_ff <= pendFlags_ff;
    end else if (wrTake) begin
      if (address == amu_pkg::OFS_ACC) acc_ff <= beMerge(acc_ff, writedata, byteenable);
      if (address == amu_pkg::OFS_OPND) opnd_ff <= beMerge(opnd_ff, writedata, byteenable);
      if (address == amu_pkg::OFS_FLAGS && byteenable[0]) flags_ff <= writedata[3:0];
    end
  end

  // completion wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      doneSticky_ff <= 1'b0;
    end else if (done_ff) begin
      doneSticky_ff <= 1'b1;
    end else if (wrTake && address == amu_pkg::OFS_STATUS && byteenable[0] &&
                 writedata[amu_pkg::STAT_DONE_BIT]) begin
      doneSticky_ff <= 1'b0;
    end
  end

  assign readdata = rdData_ff;
  assign waitrequest = waitReq_ff;
  assign opBusy = busy_ff;
  assign opDone = done_ff;
endmodule : amu_core

/* File: amu_pkg.sv */
package amu_pkg;
  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_ACC = 5'h04;
  localparam logic [4:0] OFS_OPND = 5'h08;
  localparam logic [4:0] OFS_FLAGS = 5'h0C;
  localparam logic [4:0] OFS_CORR = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam int CMD_MEM_BIT = 4;
  localparam int CORR_ACC_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CYC_LSB = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [3:0] RST_OP = 4'h0;
  localparam logic [7:0] RST_CYC = 8'h00;
  // left shift that puts the operand msb at bit 31
  localparam logic [4:0] SH_BYTE = 5'h18;
  localparam logic [4:0] SH_WORD = 5'h10;
  localparam logic [4:0] SH_LONG = 5'h00;
  localparam logic [31:0] LIM_BYTE = 32'h0000_0100;
  localparam logic [31:0] LIM_WORD = 32'h0001_0000;
  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CYC_MIN = 8'h02;
  localparam logic [7:0] CYC_STEP_REG = 8'h02;
  localparam logic [7:0] CYC_STEP_REG_L = 8'h04;
  localparam logic [7:0] CYC_STEP_MEM = 8'h03;
  localparam logic [7:0] CYC_STEP_MEM_L = 8'h05;
  localparam logic [7:0] CYC_CMP_LONG = 8'h03;
  localparam logic [7:0] CYC_CMP_WORD = 8'h02;
  localparam logic [7:0] CYC_UBQ_IMP_ZERO = 8'h03;
  localparam logic [7:0] CYC_UBQ_IMP_OVF = 8'h06;
  localparam logic [7:0] CYC_UBQ_IMP_NORM = 8'h0E;
  localparam logic [7:0] CYC_UBQ_REG_ZERO = 8'h03;
  localparam logic [7:0] CYC_UBQ_REG_OVF = 8'h05;
  localparam logic [7:0] CYC_UBQ_REG_NORM = 8'h0D;
  localparam logic [7:0] CYC_UBQ_MEM_ZERO = 8'h05;
  localparam logic [7:0] CYC_UBQ_MEM_OVF = 8'h07;
  localparam logic [7:0] CYC_UBQ_MEM_NORM = 8'h11;
  localparam logic [7:0] CYC_UWQ_REG_ZERO = 8'h03;
  localparam logic [7:0] CYC_UWQ_REG_OVF = 8'h05;
  localparam logic [7:0] CYC_UWQ_REG_NORM = 8'h15;
  localparam logic [7:0] CYC_UWQ_MEM_ZERO = 8'h04;
  localparam logic [7:0] CYC_UWQ_MEM_OVF = 8'h07;
  localparam logic [7:0] CYC_UWQ_MEM_NORM = 8'h19;
  localparam logic [7:0] CYC_PROD_ZERO = 8'h03;
  localparam logic [7:0] CYC_UBP = 8'h07;
  localparam logic [7:0] CYC_UWP = 8'h0B;
  localparam logic [7:0] CYC_SBP_POS = 8'h0C;
  localparam logic [7:0] CYC_SBP_NEG = 8'h0D;
  localparam logic [7:0] CYC_SBQ_ZERO = 8'h03;
  localparam logic [7:0] CYC_SBQ_OVF_PRE = 8'h08;
  localparam logic [7:0] CYC_SBQ_OVF_POST = 8'h12;
  localparam logic [7:0] CYC_SBQ_NORM = 8'h12;
  localparam logic [7:0] CYC_SWQ_ZERO = 8'h04;
  localparam logic [7:0] CYC_SWQ_OVF_PRE = 8'h0A;
  localparam logic [7:0] CYC_SWQ_OVF_POST = 8'h1D;
  localparam logic [7:0] CYC_SWQ_NORM = 8'h1E;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD_ONE_BYTE = 4'h0, OP_SUB_ONE_BYTE = 4'h1, OP_ADD_ONE_WORD = 4'h2,
    OP_SUB_ONE_WORD = 4'h3, OP_ADD_ONE_LONG = 4'h4, OP_SUB_ONE_LONG = 4'h5,
    OP_COMPARE_LONG = 4'h6, OP_COMPARE_WORD = 4'h7, OP_UB_QUOT_IMP = 4'h8,
    OP_UB_QUOT = 4'h9, OP_UW_QUOT = 4'hA, OP_UB_PROD_IMP = 4'hB,
    OP_UW_PROD_IMP = 4'hC, OP_SB_PROD_IMP = 4'hD, OP_SB_QUOT_IMP = 4'hE,
    OP_SW_QUOT = 4'hF
  } amu_op_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_LAST = 2'b11} amu_state_t;
  typedef struct packed {logic n; logic z; logic v; logic c;} amu_flags_t;
  typedef struct packed {logic [31:0] res; amu_flags_t flg;} amu_step_t;
  typedef struct packed {
    logic [15:0] quo;
    logic [15:0] rem;
    logic zero;
    logic pre;
    logic post;
    logic neg;
  } amu_div_t;
endpackage : amu_pkg

/* File: amu_core_sva.sv */
module amu_core_sva #(parameter int CORR_W = 4) (
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset
  input wire logic [4:0] address, // address
  input wire logic read, // read
  input wire logic write, // write
  input wire logic [31:0] writedata, // wdata
  input wire logic [3:0] byteenable, // lanes
  input wire logic [31:0] readdata, // rdata
  input wire logic waitrequest, // stall
  input wire logic opBusy, // busy
  input wire logic opDone); // done
  timeunit 1ns / 1ns;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire go = write && !waitrequest && address == amu_pkg::OFS_CMD && byteenable[0];
  AST_DONE_IN_BUSY: assert property (opDone |-> opBusy) else $error("done outside busy");
  AST_DONE_LAST: assert property (opDone |=> !opBusy) else $error("busy after done");
  AST_GO_BUSY: assert property (go |=> opBusy) else $error("op not started");
  AST_BUSY_END: assert property ($rose(opBusy) |-> ##[1:99] opDone) else $error("op never done");
  AST_BYTE_TWO: assert property (go && writedata[4:0] == 5'h00 |=> !opDone ##1 opDone)
    else $error("step not 2");
  AST_LONG_FOUR: assert property (go && writedata[4:0] == 5'h04 |=> !opDone [*3] ##1 opDone)
    else $error("not 4");
  AST_CMP_THREE: assert property (go && writedata[4:0] == 5'h06 |=> !opDone [*2] ##1 opDone)
    else $error("not 3");
  AST_WR_HELD: assert property (write && opBusy |-> waitrequest) else $error("write during op");
  cover property (go);
  cover property (opDone);
  cover property (write && opBusy);
endmodule : amu_core_sva
bind amu_core amu_core_sva #(.CORR_W(CORR_W)) amu_core_sva_i (.clk_sys, .arst_n, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .opBusy, .opDone);

/* File: amu_seq.sv */
module amu_seq (
  input wire logic clk_sys, // clock
  input wire logic waitrequest, // stall
  input wire logic [31:0] readdata, // rdata
  output logic [4:0] address, // address
  output logic read, // read
  output logic write, // write
  output logic [31:0] writedata, // wdata
  output logic [3:0] byteenable); // lanes
  timeunit 1ns / 1ns;
  initial {address, read, write, writedata, byteenable} = {5'h00, 2'b00, 32'h0, 4'hF};
  // idle data is inverted so a stale write value can never look valid
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    {address, writedata, read, write} <= {a, d, ~wr, wr};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    {read, write, writedata} <= {2'b00, ~d};
  endtask : xfer
endmodule : amu_seq

/* File: amu_core_test.sv */
module amu_core_test;
  timeunit 1ns / 1ns;
  typedef struct {logic [4:0] op; logic [31:0] acc, opd; logic [7:0] cyc;
    logic [31:0] res, ro; logic [3:0] fl;} amu_case_t;
  logic clk_sys = 1'b0, arst_n = 1'b0, read, write, waitrequest, opBusy, opDone;
  logic [31:0] writedata, readdata, st, ac, od, fl, s, m, x;
  logic [4:0] address;
  logic [3:0] byteenable, f;
  int num_errors = 0, check_count = 0;
  amu_case_t cases[21] = '{'{5'h08, 32'h0064_0007, 32'h0, 8'h0E, 32'h0002_000E, 32'h0, 4'hC},
    '{5'h08, 32'h0200_0001, 32'h0, 8'h06, 32'h0200_0001, 32'h0, 4'hE}, '{5'h19, 32'h64, 32'h7, 8'h19, 32'hE, 32'h2, 4'hC},
    '{5'h0A, 32'h64, 32'h7, 8'h15, 32'hE, 32'h2, 4'hC}, '{5'h0C, 32'h0003_0005, 32'h0, 8'h0B, 32'hF, 32'h0, 4'hF},
    '{5'h0D, 32'h00FE_0003, 32'h0, 8'h0D, 32'h00FE_FFFA, 32'h0, 4'hF},
    '{5'h0F, 32'hFFFF_FF9C, 32'h7, 8'h1F, 32'hFFFF_FFF2, 32'hFFFE, 4'hC},
    '{5'h06, 32'h5, 32'h5, 8'h03, 32'h5, 32'h5, 4'h4}, '{5'h07, 32'h30005, 32'h0, 8'h02, 32'h30005, 32'h0, 4'h9},
    '{5'h0B, 32'h100010, 32'h0, 8'h07, 32'h100100, 32'h0, 4'hF}, '{5'h0B, 32'hFF, 32'h0, 8'h03, 32'h0, 32'h0, 4'hF},
    '{5'h0E, 32'hFFF60003, 32'h0, 8'h12, 32'hFFFF00FD, 32'h0, 4'hC},
    '{5'h0E, 32'h50000, 32'h0, 8'h03, 32'h50000, 32'h0, 4'hF},
    '{5'h0E, 32'hC80001, 32'h0, 8'h12, 32'hC80001, 32'h0, 4'hE},
    '{5'h0E, 32'h10000001, 32'h0, 8'h08, 32'h10000001, 32'h0, 4'hE},
    '{5'h10, 32'h0, 32'h7F, 8'h0B, 32'h0, 32'h80, 4'hB}, '{5'h19, 32'h64, 32'h0, 8'h0A, 32'h64, 32'h0, 4'hF},
    '{5'h0A, 32'h70000, 32'h1, 8'h05, 32'h70000, 32'h1, 4'hE}, '{5'h0C, 32'h1234, 32'h0, 8'h03, 32'h0, 32'h0, 4'hF},
    '{5'h0D, 32'h20003, 32'h0, 8'h0C, 32'h20006, 32'h0, 4'hF}, '{5'h1F, 32'h64, 32'h7, 8'h27, 32'hE, 32'h2, 4'hC}};
  amu_core amu_core_i (.clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .opBusy(opBusy), .opDone(opDone));
  amu_seq amu_seq_i (.clk_sys(clk_sys), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    check_count++;
    num_errors += int'(got !== exp);
    if (got !== exp) $display("unexpected at %0t: got %h want %h", $time, got, exp);
  endtask : chk
  function automatic logic [43:0] stepExp(input int i, input logic [31:0] s, input logic [31:0] x, input logic c);
    logic [31:0] m, r;
    m = (s << 1) - 32'h1;
    r = (i % 2) ? (x - 32'h1) & m : (x + 32'h1) & m;
    return {(i % 6 < 4) ? 8'h02 : 8'h04, r, |(r & s), r == 32'h0, (i % 2) ? x == s : x == m >> 1, c};
  endfunction : stepExp
  task automatic run(input logic [4:0] op, input logic [31:0] a, input logic [31:0] d, input logic [3:0] fp);
    amu_seq_i.xfer(1'b1, amu_pkg::OFS_ACC, a, st);
    amu_seq_i.xfer(1'b1, amu_pkg::OFS_OPND, d, st);
    amu_seq_i.xfer(1'b1, amu_pkg::OFS_FLAGS, {28'h0, fp}, st);
    amu_seq_i.xfer(1'b1, amu_pkg::OFS_CMD, {27'h0, op}, st);
    // unmapped write is held off until the op ends, so no polling is needed
    amu_seq_i.xfer(1'b1, 5'h18, 32'h0, st);
    amu_seq_i.xfer(1'b0, amu_pkg::OFS_STATUS, 32'h0, st);
    amu_seq_i.xfer(1'b0, amu_pkg::OFS_ACC, 32'h0, ac);
    amu_seq_i.xfer(1'b0, amu_pkg::OFS_OPND, 32'h0, od);
    amu_seq_i.xfer(1'b0, amu_pkg::OFS_FLAGS, 32'h0, fl);
  endtask : run
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(18842));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    amu_seq_i.xfer(1'b1, amu_pkg::OFS_CORR, 32'h0000_0302, st);
    for (int i = 0; i < 24; i++) begin
      s = (i % 6 < 2) ? 32'h80 : (i % 6 < 4) ? 32'h8000 : 32'h8000_0000;
      m = (s << 1) - 32'h1;
      x = (i < 6) ? s - 32'h1 : (i < 12) ? s : (i < 18) ? m : $urandom & m;
      f = 4'($urandom);
      run(5'(i % 6), 32'h0, x, f);
      chk({st[15:8], od, fl[3:0]}, stepExp(i, s, x, f[0]));
    end
    foreach (cases[k]) begin
      run(cases[k].op, cases[k].acc, cases[k].opd, 4'hF);
      chk({36'h0, st[15:8]}, {36'h0, cases[k].cyc});
      chk({12'h0, ac}, {12'h0, cases[k].res});
      chk({12'h0, od}, {12'h0, cases[k].ro});
      chk({40'h0, fl[3:0]}, {40'h0, cases[k].fl});
    end
    close_out();
  end
endmodule : amu_core_test
